// file: hw/ancillary_pkg.sv
// Constants and types shared by the ancillary state register file
package ancillary_pkg;

	// Register indices as decoded from the instruction
	localparam logic [4:0] IDX_PRODUCT_HIGH = 5'h00;
	localparam logic [4:0] IDX_RESERVED_1 = 5'h01;
	localparam logic [4:0] IDX_FLAGS = 5'h02;
	localparam logic [4:0] IDX_ADDR_SPACE = 5'h03;
	localparam logic [4:0] IDX_CYCLE = 5'h04;
	localparam logic [4:0] IDX_PROG_COUNTER = 5'h05;
	localparam logic [4:0] IDX_FP_STATE = 5'h06;
	localparam logic [4:0] IDX_RESERVED_LO = 5'h07;
	localparam logic [4:0] IDX_RESERVED_HI = 5'h0F;
	localparam logic [4:0] IDX_PERF_CONTROL = 5'h10;
	localparam logic [4:0] IDX_PERF_COUNTERS = 5'h11;
	localparam logic [4:0] IDX_IMPL_18 = 5'h12;
	localparam logic [4:0] IDX_GENERAL_STATUS = 5'h13;
	localparam logic [4:0] IDX_SOFT_INTERRUPT_SET_ALIAS = 5'h14;
	localparam logic [4:0] IDX_SOFT_INTERRUPT_REG_CLEAR = 5'h15;
	localparam logic [4:0] IDX_SOFT_INTERRUPT_REG = 5'h16;
	localparam logic [4:0] IDX_CYCLE_COMPARE = 5'h17;
	localparam logic [4:0] IDX_SYS_TICK = 5'h18;
	localparam logic [4:0] IDX_SYS_TICK_COMPARE = 5'h19;
	localparam logic [4:0] IDX_IMPL_LO = 5'h1A;

	// Integer flag register field positions
	localparam int FLAG_XN = 7;
	localparam int FLAG_XZ = 6;
	localparam int FLAG_XV = 5;
	localparam int FLAG_XC = 4;
	localparam int FLAG_IN = 3;
	localparam int FLAG_IZ = 2;
	localparam int FLAG_IV = 1;
	localparam int FLAG_IC = 0;
	localparam int FLAG_W = 8;
	localparam int HALF_W = 32;

	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [31:0] PRODUCT_HIGH_RESET = 32'h0000_0000;
	localparam logic [63:0] WORD_RESET = 64'h0000_0000_0000_0000;
	localparam logic [31:0] READ_ZERO_HIGH = 32'h0000_0000;

	// Kind of flag-setting operation reported by the ALU
	typedef enum logic [1:0] {
		FLAG_OP_ADD,
		FLAG_OP_SUB,
		FLAG_OP_LOGIC
	} flag_op_t;

endpackage

// file: hw/ancillary_state_regs_flags.sv
// Per-processor ancillary state register file with product-high and integer flags
`timescale 1ns/1ns
`default_nettype none

module ancillary_state_regs_flags #(
	parameter int NUM_VP = 4,
	parameter int VP_W = (NUM_VP > 1) ? $clog2(NUM_VP) : 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [4:0] acc_index,
	input wire logic [VP_W-1:0] acc_vp,
	input wire logic [63:0] acc_wdata,
	input wire logic priv_mode,
	input wire logic tick_user_read_en,
	output logic acc_priv_fault,
	output logic acc_undecoded,
	output logic acc_rvalid,
	output logic [63:0] acc_rdata,
	input wire logic [63:0] prog_counter_in,
	input wire logic alu_valid,
	input wire logic [VP_W-1:0] alu_vp,
	input wire ancillary_pkg::flag_op_t alu_op,
	input wire logic [63:0] alu_opnd_a,
	input wire logic [63:0] alu_opnd_b,
	input wire logic [63:0] alu_result,
	input wire logic mul_valid,
	input wire logic [VP_W-1:0] mul_vp,
	input wire logic [63:0] mul_product,
	input wire logic [VP_W-1:0] div_vp,
	output logic [31:0] div_dividend_high,
	input wire logic trap_ret_valid,
	input wire logic [VP_W-1:0] trap_ret_vp,
	input wire logic [7:0] saved_trap_flags,
	input wire logic [VP_W-1:0] cond_vp,
	output logic [3:0] cond_wide_flags,
	output logic [3:0] cond_narrow_flags,
	output logic [3:0] legacy_branch_flags,
	output logic [63:0] address_space_select
);
	import ancillary_pkg::*;

	// Per virtual processor storage, never shared between processors
	logic [31:0] product_high_reg [NUM_VP];
	logic [7:0] flags_reg [NUM_VP];
	logic [7:0] flags_next [NUM_VP];
	logic [63:0] asi_reg [NUM_VP];
	logic [62:0] cycle_reg [NUM_VP];
	logic [63:0] fp_state_reg [NUM_VP];
	logic [63:0] perf_ctl_reg [NUM_VP];
	logic [63:0] perf_cnt_reg [NUM_VP];
	logic [63:0] gen_status_reg [NUM_VP];
	logic [63:0] soft_interrupt_reg_reg [NUM_VP];
	logic [63:0] cycle_cmp_reg [NUM_VP];
	logic [63:0] sys_tick_reg [NUM_VP];
	logic [63:0] sys_cmp_reg [NUM_VP];
	logic [63:0] rdata_next;
	logic [7:0] alu_flags;
	logic wr_fire;
	logic rd_fire;
	logic flag_wr;
	logic [4:0] rd_index_reg;

	// Known registers and the direction each one supports
	function automatic logic index_decoded(input logic [4:0] idx, input logic wr);
		logic ok;
		ok = 1'b0;
		if (idx == IDX_PRODUCT_HIGH || idx == IDX_FLAGS || idx == IDX_ADDR_SPACE) begin
			ok = 1'b1;
		end else if (idx == IDX_CYCLE || idx == IDX_PROG_COUNTER || idx == IDX_SYS_TICK) begin
			ok = !wr; // Counters and PC have no write path here
		end else if (idx == IDX_FP_STATE || idx == IDX_PERF_CONTROL) begin
			ok = 1'b1;
		end else if (idx == IDX_PERF_COUNTERS || idx == IDX_GENERAL_STATUS) begin
			ok = 1'b1;
		end else if (idx == IDX_SOFT_INTERRUPT_SET_ALIAS || idx == IDX_SOFT_INTERRUPT_REG_CLEAR) begin
			ok = wr; // Pseudo-registers are write only
		end else if (idx == IDX_SOFT_INTERRUPT_REG || idx == IDX_CYCLE_COMPARE) begin
			ok = 1'b1;
		end else if (idx == IDX_SYS_TICK_COMPARE) begin
			ok = 1'b1;
		end else begin
			ok = 1'b0; // 1, 7-15, 18 and 26-31 hold nothing
		end
		return ok;
	endfunction

	// Privilege needed for an access; tick reads open to users when enabled
	function automatic logic index_privileged(input logic [4:0] idx, input logic user_tick);
		logic p;
		p = 1'b0;
		if (idx == IDX_CYCLE || idx == IDX_SYS_TICK) begin
			p = !user_tick;
		end else if (idx >= IDX_PERF_CONTROL && idx <= IDX_SYS_TICK_COMPARE) begin
			p = (idx != IDX_GENERAL_STATUS) && (idx != IDX_IMPL_18);
		end else begin
			p = 1'b0;
		end
		return p;
	endfunction

	// Both flag groups from one result, wide then narrow
	function automatic logic [7:0] flags_calc(input flag_op_t op, input logic [63:0] a,
			input logic [63:0] b, input logic [63:0] r);
		logic [63:0] cy;
		logic [7:0] f;
		cy = (a & b) | ((a | b) & ~r);
		f = FLAGS_RESET;
		f[FLAG_XN] = r[63];
		f[FLAG_IN] = r[31];
		f[FLAG_XZ] = (r == 64'h0000_0000_0000_0000);
		f[FLAG_IZ] = (r[31:0] == 32'h0000_0000);
		case (op)
			FLAG_OP_ADD: begin
				f[FLAG_XV] = (a[63] == b[63]) && (r[63] != a[63]);
				f[FLAG_IV] = (a[31] == b[31]) && (r[31] != a[31]);
				f[FLAG_XC] = cy[63];
				f[FLAG_IC] = cy[31];
			end
			FLAG_OP_SUB: begin
				f[FLAG_XV] = (a[63] != b[63]) && (r[63] != a[63]);
				f[FLAG_IV] = (a[31] != b[31]) && (r[31] != a[31]);
				f[FLAG_XC] = (a < b);
				f[FLAG_IC] = (a[31:0] < b[31:0]);
			end
			default: begin
				f[FLAG_XV] = 1'b0;
				f[FLAG_IV] = 1'b0;
				f[FLAG_XC] = 1'b0;
				f[FLAG_IC] = 1'b0;
			end
		endcase
		return f;
	endfunction

	// Access qualification; a refused access updates nothing
	always_comb begin
		acc_undecoded = acc_valid && !index_decoded(acc_index, acc_write);
		acc_priv_fault = acc_valid && !acc_undecoded && !priv_mode &&
			index_privileged(acc_index, tick_user_read_en && !acc_write);
		wr_fire = acc_valid && acc_write && !acc_undecoded && !acc_priv_fault;
		rd_fire = acc_valid && !acc_write && !acc_undecoded && !acc_priv_fault;
		flag_wr = wr_fire && (acc_index == IDX_FLAGS);
	end

	// Next flags: trap return, then explicit write, then ALU result
	always_comb begin
		alu_flags = flags_calc(alu_op, alu_opnd_a, alu_opnd_b, alu_result);
		for (int v = 0; v < NUM_VP; v++) begin
			flags_next[v] = flags_reg[v];
			if (trap_ret_valid && trap_ret_vp == VP_W'(v)) begin
				flags_next[v] = saved_trap_flags;
			end else if (flag_wr && acc_vp == VP_W'(v)) begin
				flags_next[v] = acc_wdata[FLAG_W-1:0];
			end else if (alu_valid && alu_vp == VP_W'(v)) begin
				flags_next[v] = alu_flags;
			end
		end
	end

	// Flags register; next instruction sees the new value
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int v = 0; v < NUM_VP; v++) begin
				flags_reg[v] <= FLAGS_RESET;
			end
		end else begin
			for (int v = 0; v < NUM_VP; v++) begin
				flags_reg[v] <= flags_next[v];
			end
		end
	end

	// Product-high: multiply result wins over a same-cycle explicit write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int v = 0; v < NUM_VP; v++) begin
				product_high_reg[v] <= PRODUCT_HIGH_RESET;
			end
		end else begin
			for (int v = 0; v < NUM_VP; v++) begin
				if (mul_valid && mul_vp == VP_W'(v)) begin
					product_high_reg[v] <= mul_product[63:32];
				end else if (wr_fire && acc_index == IDX_PRODUCT_HIGH && acc_vp == VP_W'(v)) begin
					product_high_reg[v] <= acc_wdata[31:0]; // upper half dropped
				end
			end
		end
	end

	// Free-running counters, one set per processor
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int v = 0; v < NUM_VP; v++) begin
				cycle_reg[v] <= WORD_RESET[62:0];
				sys_tick_reg[v] <= WORD_RESET;
			end
		end else begin
			for (int v = 0; v < NUM_VP; v++) begin
				cycle_reg[v] <= cycle_reg[v] + 63'h1;
				sys_tick_reg[v] <= sys_tick_reg[v] + 64'h1;
			end
		end
	end

	// Plain read-write words and the soft interrupt set and clear aliases
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int v = 0; v < NUM_VP; v++) begin
				asi_reg[v] <= WORD_RESET;
				fp_state_reg[v] <= WORD_RESET;
				perf_ctl_reg[v] <= WORD_RESET;
				perf_cnt_reg[v] <= WORD_RESET;
				gen_status_reg[v] <= WORD_RESET;
				soft_interrupt_reg_reg[v] <= WORD_RESET;
				cycle_cmp_reg[v] <= WORD_RESET;
				sys_cmp_reg[v] <= WORD_RESET;
			end
		end else if (wr_fire) begin
			for (int v = 0; v < NUM_VP; v++) begin
				if (acc_vp == VP_W'(v)) begin
					if (acc_index == IDX_ADDR_SPACE) begin
						asi_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_FP_STATE) begin
						fp_state_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_PERF_CONTROL) begin
						perf_ctl_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_PERF_COUNTERS) begin
						perf_cnt_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_GENERAL_STATUS) begin
						gen_status_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_SOFT_INTERRUPT_SET_ALIAS) begin
						soft_interrupt_reg_reg[v] <= soft_interrupt_reg_reg[v] | acc_wdata;
					end else if (acc_index == IDX_SOFT_INTERRUPT_REG_CLEAR) begin
						soft_interrupt_reg_reg[v] <= soft_interrupt_reg_reg[v] & ~acc_wdata;
					end else if (acc_index == IDX_SOFT_INTERRUPT_REG) begin
						soft_interrupt_reg_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_CYCLE_COMPARE) begin
						cycle_cmp_reg[v] <= acc_wdata;
					end else if (acc_index == IDX_SYS_TICK_COMPARE) begin
						sys_cmp_reg[v] <= acc_wdata;
					end
				end
			end
		end
	end

	// Read selection by index, before the output flop
	always_comb begin
		rdata_next = WORD_RESET;
		if (acc_index == IDX_PRODUCT_HIGH) begin
			rdata_next = {READ_ZERO_HIGH, product_high_reg[acc_vp]};
		end else if (acc_index == IDX_FLAGS) begin
			rdata_next = {56'h0, flags_reg[acc_vp]};
		end else if (acc_index == IDX_ADDR_SPACE) begin
			rdata_next = asi_reg[acc_vp];
		end else if (acc_index == IDX_CYCLE) begin
			rdata_next = {!tick_user_read_en, cycle_reg[acc_vp]};
		end else if (acc_index == IDX_PROG_COUNTER) begin
			rdata_next = {prog_counter_in[63:2], 2'h0};
		end else if (acc_index == IDX_FP_STATE) begin
			rdata_next = fp_state_reg[acc_vp];
		end else if (acc_index == IDX_PERF_CONTROL) begin
			rdata_next = perf_ctl_reg[acc_vp];
		end else if (acc_index == IDX_PERF_COUNTERS) begin
			rdata_next = perf_cnt_reg[acc_vp];
		end else if (acc_index == IDX_GENERAL_STATUS) begin
			rdata_next = gen_status_reg[acc_vp];
		end else if (acc_index == IDX_SOFT_INTERRUPT_REG) begin
			rdata_next = soft_interrupt_reg_reg[acc_vp];
		end else if (acc_index == IDX_CYCLE_COMPARE) begin
			rdata_next = cycle_cmp_reg[acc_vp];
		end else if (acc_index == IDX_SYS_TICK) begin
			rdata_next = sys_tick_reg[acc_vp];
		end else if (acc_index == IDX_SYS_TICK_COMPARE) begin
			rdata_next = sys_cmp_reg[acc_vp];
		end
	end

	// Read answer one cycle after the request; refused reads give no answer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			acc_rvalid <= 1'b0;
			acc_rdata <= WORD_RESET;
			rd_index_reg <= IDX_PRODUCT_HIGH;
		end else begin
			acc_rvalid <= rd_fire;
			if (rd_fire) begin
				acc_rdata <= rdata_next;
				rd_index_reg <= acc_index;
			end
		end
	end

	// Consumers: divide, conditionals and alternate-space accesses
	always_comb begin
		div_dividend_high = product_high_reg[div_vp];
		cond_wide_flags = flags_reg[cond_vp][FLAG_XN:FLAG_XC];
		cond_narrow_flags = flags_reg[cond_vp][FLAG_IN:FLAG_IC];
		legacy_branch_flags = flags_reg[cond_vp][FLAG_IN:FLAG_IC]; // Narrow group only
		address_space_select = asi_reg[cond_vp];
	end

	// Checks on the behaviour above
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_y_high_zero: assert property (
		acc_rvalid && rd_index_reg == IDX_PRODUCT_HIGH |-> acc_rdata[63:32] == 32'h0000_0000)
		else $error("product-high upper half read nonzero");

	a_priv_perf_block: assert property (
		acc_valid && !priv_mode && acc_index == IDX_PERF_CONTROL |-> acc_priv_fault ##1 !acc_rvalid)
		else $error("user access to privileged register not refused");

	a_reserved_undecoded: assert property (
		acc_valid && (acc_index == IDX_RESERVED_1 || acc_index == IDX_IMPL_18 ||
			acc_index >= IDX_IMPL_LO) |-> acc_undecoded && !acc_priv_fault)
		else $error("reserved index not reported undecoded");

	a_mul_to_divide: assert property (
		mul_valid ##1 div_vp == $past(mul_vp) |-> div_dividend_high == $past(mul_product[63:32]))
		else $error("product upper word not in product-high");

	a_logic_zero_flags: assert property (
		alu_valid && alu_op == FLAG_OP_LOGIC && alu_result == 64'h0000_0000_0000_0000 &&
			!trap_ret_valid && !flag_wr |=> flags_reg[$past(alu_vp)] == 8'h44)
		else $error("zero result did not set both zero flags");

	a_sub_borrow: assert property (
		alu_valid && alu_op == FLAG_OP_SUB && !trap_ret_valid && !flag_wr
			|=> flags_reg[$past(alu_vp)][FLAG_XC] == ($past(alu_opnd_a) < $past(alu_opnd_b)))
		else $error("wide borrow flag wrong after subtract");

	a_trap_restore: assert property (
		trap_ret_valid |=> flags_reg[$past(trap_ret_vp)] == $past(saved_trap_flags))
		else $error("trap return did not restore flags");

	a_soft_interrupt_set_alias: assert property (
		wr_fire && acc_index == IDX_SOFT_INTERRUPT_SET_ALIAS
			|=> (soft_interrupt_reg_reg[$past(acc_vp)] & $past(acc_wdata)) == $past(acc_wdata))
		else $error("soft interrupt set alias lost a bit");

	a_flag_write_read: assert property (
		flag_wr && !trap_ret_valid ##1 rd_fire && acc_index == IDX_FLAGS &&
			acc_vp == $past(acc_vp) && !trap_ret_valid
			|=> acc_rdata[7:0] == $past(acc_wdata[7:0], 2))
		else $error("flag register write not read back");

	a_flags_hold: assert property (
		!alu_valid && !trap_ret_valid && !flag_wr |=> flags_reg[$past(cond_vp)] ==
			$past(flags_reg[cond_vp]))
		else $error("flags changed without a flag-setting source");

endmodule

`default_nettype wire

// file: testbench/ancillary_state_regs_flags_tb_top.sv
// Self-checking bench for the ancillary state register file
`timescale 1ns/1ns
`default_nettype none
module ancillary_state_regs_flags_tb_top;
	import ancillary_pkg::*;

	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic acc_valid = 1'b0;
	logic acc_write = 1'b0;
	logic [4:0] acc_index = 5'h00;
	logic [1:0] acc_vp = 2'h0;
	logic [63:0] acc_wdata = 64'h0;
	logic priv_mode = 1'b1;
	logic tick_user_read_en = 1'b0;
	logic [63:0] prog_counter_in = 64'h0000_0000_1234_5677;
	logic [1:0] div_vp = 2'h0;
	logic [1:0] cond_vp = 2'h0;
	logic acc_priv_fault, acc_undecoded, acc_rvalid, alu_valid, mul_valid, trap_ret_valid;
	logic [63:0] acc_rdata, alu_opnd_a, alu_opnd_b, alu_result, mul_product, address_space_select;
	logic [1:0] alu_vp, mul_vp, trap_ret_vp;
	flag_op_t alu_op;
	logic [7:0] saved_trap_flags;
	logic [31:0] div_dividend_high;
	logic [3:0] cond_wide_flags, cond_narrow_flags, legacy_branch_flags;
	int mismatches = 0;
	int comparisons = 0;
	// Flag cases with hand-worked results: wide and narrow views differ in five of the eight
	flag_op_t t_op [8] = '{FLAG_OP_SUB, FLAG_OP_SUB, FLAG_OP_SUB, FLAG_OP_ADD, FLAG_OP_ADD,
		FLAG_OP_ADD, FLAG_OP_ADD, FLAG_OP_LOGIC};
	logic [63:0] t_a [8] = '{64'h1, 64'h0, 64'h1_0000_0000, 64'hFFFF_FFFF, 64'h7FFF_FFFF_FFFF_FFFF,
		64'h7FFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF};
	logic [63:0] t_b [8] = '{64'h2, 64'h0, 64'h1, 64'h1, 64'h1, 64'h1, 64'h1, 64'hFFFF_FFFF_FFFF_FFFF};
	logic [7:0] t_exp [8] = '{8'h99, 8'h44, 8'h09, 8'h05, 8'hA5, 8'h0A, 8'h55, 8'h08};
	logic [4:0] rw_idx [7] = '{5'h03, 5'h06, 5'h10, 5'h11, 5'h13, 5'h17, 5'h19};
	logic [4:0] bad_idx [6] = '{5'h01, 5'h07, 5'h0F, 5'h12, 5'h1A, 5'h1F};

	// Core clock, 8 ns period
	always #4 clock = ~clock;

	ancillary_state_regs_flags #(.NUM_VP(4)) ancillary_state_regs_flags_inst (
		.clock(clock), .reset_n(reset_n), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_index(acc_index), .acc_vp(acc_vp), .acc_wdata(acc_wdata), .priv_mode(priv_mode),
		.tick_user_read_en(tick_user_read_en), .acc_priv_fault(acc_priv_fault),
		.acc_undecoded(acc_undecoded), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata),
		.prog_counter_in(prog_counter_in), .alu_valid(alu_valid), .alu_vp(alu_vp),
		.alu_op(alu_op), .alu_opnd_a(alu_opnd_a), .alu_opnd_b(alu_opnd_b),
		.alu_result(alu_result), .mul_valid(mul_valid), .mul_vp(mul_vp),
		.mul_product(mul_product), .div_vp(div_vp), .div_dividend_high(div_dividend_high),
		.trap_ret_valid(trap_ret_valid), .trap_ret_vp(trap_ret_vp),
		.saved_trap_flags(saved_trap_flags), .cond_vp(cond_vp),
		.cond_wide_flags(cond_wide_flags), .cond_narrow_flags(cond_narrow_flags),
		.legacy_branch_flags(legacy_branch_flags), .address_space_select(address_space_select));

	exec_pipe_model exec_pipe_model_inst (
		.clock(clock), .alu_valid(alu_valid), .alu_vp(alu_vp), .alu_op(alu_op),
		.alu_opnd_a(alu_opnd_a), .alu_opnd_b(alu_opnd_b), .alu_result(alu_result),
		.mul_valid(mul_valid), .mul_vp(mul_vp), .mul_product(mul_product),
		.trap_ret_valid(trap_ret_valid), .trap_ret_vp(trap_ret_vp),
		.saved_trap_flags(saved_trap_flags));

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One access cycle; refuse is {privilege fault, undecoded} expected while it is presented
	task automatic access(input logic wr, input logic [4:0] idx, input logic [1:0] vp,
		input logic pm, input logic [63:0] wd, input logic [63:0] mask, input logic [63:0] exp,
		input logic [1:0] refuse);
		@(negedge clock);
		acc_valid = 1'b1;
		acc_write = wr;
		acc_index = idx;
		acc_vp = vp;
		priv_mode = pm;
		acc_wdata = wd;
		#1;
		check({62'h0, acc_priv_fault, acc_undecoded}, {62'h0, refuse}, "refusal flags");
		@(negedge clock);
		acc_valid = 1'b0;
		acc_wdata = ~wd;
		if (!wr) check({63'h0, acc_rvalid}, {63'h0, refuse == 2'b00}, "read valid");
		if (!wr && refuse == 2'b00) check(acc_rdata & mask, exp, "read data");
	endtask

	task automatic wr_reg(input logic [4:0] idx, input logic [1:0] vp, input logic [63:0] wd);
		access(1'b1, idx, vp, 1'b1, wd, 64'h0, 64'h0, 2'b00);
	endtask

	task automatic rd_reg(input logic [4:0] idx, input logic [1:0] vp, input logic [63:0] exp);
		access(1'b0, idx, vp, 1'b1, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, exp, 2'b00);
	endtask

	// Flags seen by branches and moves of one processor
	task automatic check_flags(input logic [1:0] vp, input logic [7:0] exp);
		cond_vp = vp;
		#1;
		check({56'h0, cond_wide_flags, cond_narrow_flags}, {56'h0, exp}, "flags");
		check({60'h0, legacy_branch_flags}, {60'h0, exp[3:0]}, "legacy flags");
	endtask

	// Watchdog: a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		final_report();
	end

	initial begin
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		rd_reg(IDX_FLAGS, 2'h0, 64'h0);
		wr_reg(IDX_PRODUCT_HIGH, 2'h0, 64'hDEAD_BEEF_1234_5678);
		rd_reg(IDX_PRODUCT_HIGH, 2'h0, 64'h0000_0000_1234_5678);
		div_vp = 2'h0;
		#1;
		check({32'h0, div_dividend_high}, 64'h1234_5678, "dividend high");
		exec_pipe_model_inst.retire(1'b0, FLAG_OP_ADD, 64'h0, 64'h0, 2'h0, 1'b0, 8'h00, 1'b1,
			32'hFFFF_FFFF, 32'hFFFF_FFFF);
		rd_reg(IDX_PRODUCT_HIGH, 2'h0, 64'h0000_0000_FFFF_FFFE);
		check_flags(2'h0, 8'h00);
		// Flag-setting results, one every other cycle
		for (int i = 0; i < 8; i++) begin
			exec_pipe_model_inst.retire(1'b1, t_op[i], t_a[i], t_b[i], 2'h0, 1'b0, 8'h00, 1'b0,
				32'h0, 32'h0);
			check_flags(2'h0, t_exp[i]);
		end
		wr_reg(IDX_FLAGS, 2'h1, 64'hFFFF_FFFF_FFFF_FFF0);
		rd_reg(IDX_FLAGS, 2'h1, 64'h0000_0000_0000_00F0);
		check_flags(2'h0, 8'h08);
		// Trap return and an ALU result in the same cycle: the saved flags win
		exec_pipe_model_inst.retire(1'b1, FLAG_OP_SUB, 64'h1, 64'h2, 2'h1, 1'b1, 8'h3C, 1'b0,
			32'h0, 32'h0);
		check_flags(2'h1, 8'h3C);
		wr_reg(IDX_SOFT_INTERRUPT_REG, 2'h0, 64'h0);
		wr_reg(IDX_SOFT_INTERRUPT_SET_ALIAS, 2'h0, 64'h0F);
		wr_reg(IDX_SOFT_INTERRUPT_REG_CLEAR, 2'h0, 64'h05);
		rd_reg(IDX_SOFT_INTERRUPT_REG, 2'h0, 64'h0A);
		// Plain storage indices, each with its own pattern
		foreach (rw_idx[i]) begin
			wr_reg(rw_idx[i], 2'h2, {8'hA5, 51'h0, rw_idx[i]});
			rd_reg(rw_idx[i], 2'h2, {8'hA5, 51'h0, rw_idx[i]});
		end
		check_flags(2'h2, 8'h00);
		check(address_space_select, 64'hA500_0000_0000_0003, "address space");
		rd_reg(IDX_PROG_COUNTER, 2'h0, 64'h0000_0000_1234_5674);
		// User mode: privileged, unprivileged and counter-gated accesses
		access(1'b0, IDX_PERF_CONTROL, 2'h0, 1'b0, 64'h0, 64'h0, 64'h0, 2'b10);
		access(1'b1, IDX_SOFT_INTERRUPT_SET_ALIAS, 2'h0, 1'b0, 64'hF0, 64'h0, 64'h0, 2'b10);
		rd_reg(IDX_SOFT_INTERRUPT_REG, 2'h0, 64'h0A);
		access(1'b0, IDX_GENERAL_STATUS, 2'h2, 1'b0, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF,
			64'hA500_0000_0000_0013, 2'b00);
		access(1'b0, IDX_CYCLE, 2'h0, 1'b0, 64'h0, 64'h0, 64'h0, 2'b10);
		tick_user_read_en = 1'b1;
		access(1'b0, IDX_CYCLE, 2'h0, 1'b0, 64'h0, 64'h8000_0000_0000_0000, 64'h0, 2'b00);
		// Reserved and implementation indices, and refused directions
		foreach (bad_idx[i]) begin
			access(1'b0, bad_idx[i], 2'h0, 1'b1, 64'h0, 64'h0, 64'h0, 2'b01);
		end
		access(1'b1, IDX_PROG_COUNTER, 2'h0, 1'b1, 64'h0, 64'h0, 64'h0, 2'b01);
		access(1'b0, IDX_SOFT_INTERRUPT_SET_ALIAS, 2'h0, 1'b1, 64'h0, 64'h0, 64'h0, 2'b01);
		// Second reset in mid-run clears the flags again
		@(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		check_flags(2'h1, 8'h00);
		rd_reg(IDX_PRODUCT_HIGH, 2'h0, 64'h0);
		final_report();
	end
endmodule
`default_nettype wire

// file: testbench/exec_pipe_model.sv
// Behavioural model of the integer pipeline that retires flag, multiply and trap-return work
`timescale 1ns/1ns
`default_nettype none
module exec_pipe_model (
	input wire logic clock,
	output var logic alu_valid,
	output var logic [1:0] alu_vp,
	output var ancillary_pkg::flag_op_t alu_op,
	output var logic [63:0] alu_opnd_a,
	output var logic [63:0] alu_opnd_b,
	output var logic [63:0] alu_result,
	output var logic mul_valid,
	output var logic [1:0] mul_vp,
	output var logic [63:0] mul_product,
	output var logic trap_ret_valid,
	output var logic [1:0] trap_ret_vp,
	output var logic [7:0] saved_trap_flags
);
	import ancillary_pkg::*;

	// Quiet pipeline until the bench asks for a retirement
	initial begin
		alu_valid = 1'b0;
		alu_vp = 2'h0;
		alu_op = FLAG_OP_ADD;
		alu_opnd_a = 64'h0;
		alu_opnd_b = 64'h0;
		alu_result = 64'h0;
		mul_valid = 1'b0;
		mul_vp = 2'h0;
		mul_product = 64'h0;
		trap_ret_valid = 1'b0;
		trap_ret_vp = 2'h0;
		saved_trap_flags = 8'h00;
	end

	// One retirement slot held across exactly one rising edge; result, product and
	// saved flags are inverted afterwards so a stale value can never pass for a live one
	task automatic retire(input logic av, input flag_op_t op, input logic [63:0] a,
		input logic [63:0] b, input logic [1:0] vp, input logic tv, input logic [7:0] tf,
		input logic mv, input logic [31:0] ma, input logic [31:0] mb);
		@(negedge clock);
		alu_valid = av;
		alu_vp = vp;
		alu_op = op;
		alu_opnd_a = a;
		alu_opnd_b = b;
		alu_result = (op == FLAG_OP_ADD) ? a + b : ((op == FLAG_OP_SUB) ? a - b : a & b);
		mul_valid = mv;
		mul_vp = vp;
		mul_product = {32'h0, ma} * {32'h0, mb};
		trap_ret_valid = tv;
		trap_ret_vp = vp;
		saved_trap_flags = tf;
		@(negedge clock);
		alu_valid = 1'b0;
		mul_valid = 1'b0;
		trap_ret_valid = 1'b0;
		alu_result = ~alu_result;
		mul_product = ~mul_product;
		saved_trap_flags = ~saved_trap_flags;
	endtask
endmodule
`default_nettype wire
